//--- logic/rx_lane_pkg.sv
// Constants shared by the shared-lane receive stage and its FIFO.
// Assumes a single 250 MHz core clock; link clocks are sampled as data.
package rx_lane_pkg;
  localparam int LANE_W = 5;
  localparam int NIB_W = 4;
  localparam int LANE_VALID = 4;
  localparam int FIFO_W = 9;
  localparam int FIFO_DEPTH = 8;
  localparam int OUT_START_BIT = 8;
  localparam int OUT_BYTE_LSB = 0;
  localparam int OUT_BYTE_MSB = 7;
  localparam int CLK_PERIOD_NS = 4;
  localparam int MII_FAST_MHZ_X10 = 250;
  localparam int MII_SLOW_MHZ_X10 = 25;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] NIB_RESET = 4'h0;
  typedef enum logic [1:0] {MODE_CELL, MODE_MII, MODE_SMII, MODE_RSVD} lane_mode_t;
  typedef enum {ST_IDLE, ST_CELL, ST_MII_LO, ST_MII_HI} rx_state_t;
endpackage : rx_lane_pkg

//--- logic/rx_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides on the same clock; depth is a power of two.
`timescale 1ns/1ps
module rx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic arst_n,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;

  always_comb begin
    in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    out_valid = wr_ptr != rd_ptr;
    out_data = mem[rd_ptr[AW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage carries no reset; only pointers define content.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule : rx_fifo

//--- logic/cell_mii_rx_pin_mux.sv
// Receive input stage of a shared cell / MII / SMII port.
// Assumes pins and link clocks arrive asynchronously to ref_clk, which
// runs at least four times faster than any link clock.
`timescale 1ns/1ps
// Behaviour
// - cell_start_in high marks first cell byte.
// - cell mode uses lanes 4 and 3:0 as data.
// - MII nibble on lanes 3:0 captured by link_rx_clk.
// - lane 4 is MII valid; accept only then.
// - no address filtering on this path.
// - SMII mode ignores data and valid lanes.
// - disabled port ignores every receive input.
// - cell inputs sampled on link_rx_clk rising edge.
module cell_mii_rx_pin_mux
  import rx_lane_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic arst_n,
  // Static configuration.
  input wire logic port_enable,
  input wire rx_lane_pkg::lane_mode_t mode_select,
  // Pins from the physical-layer device.
  input wire logic link_rx_clk,
  input wire logic cell_start_in,
  input wire logic [rx_lane_pkg::LANE_W-1:0] shared_rx_lanes,
  // Received byte stream.
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_byte,
  output logic rx_start,
  // Status.
  output logic rx_overflow,
  output logic rx_active
);
  import rx_lane_pkg::*;

  // Two-stage synchronisers, one per pin, the link clock included. They
  // reset high, the pins' pull-up level, so a link clock that rests high
  // once reset lets go is not taken for a rising edge.
  logic [LANE_W+1:0] pins;
  wire [LANE_W+1:0] sync2;
  logic clk_prev;
  logic next_clk_prev;

  assign pins = {link_rx_clk, cell_start_in, shared_rx_lanes};

  for (genvar b = 0; b < LANE_W + 2; b++) begin : g_sync
    logic stage1;
    logic stage2;
    logic next_stage1;
    logic next_stage2;

    always_comb begin
      next_stage1 = pins[b];
      next_stage2 = stage1;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        stage1 <= 1'b1;
        stage2 <= 1'b1;
      end else begin
        stage1 <= next_stage1;
        stage2 <= next_stage2;
      end
    end

    assign sync2[b] = stage2;
  end

  logic s_clk;
  logic s_start;
  logic [LANE_W-1:0] s_lanes;
  logic link_rise;
  assign s_clk = sync2[LANE_W+1];
  assign s_start = sync2[LANE_W];
  assign s_lanes = sync2[LANE_W-1:0];
  // The lanes were synchronised with the clock, so at the sampled rising
  // edge they carry the values the PHY set up before that edge.
  assign link_rise = s_clk && !clk_prev;

  always_comb begin
    next_clk_prev = s_clk;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_prev <= 1'b1;
    end else begin
      clk_prev <= next_clk_prev;
    end
  end

  // Mode is latched while idle so a live change cannot split a unit.
  rx_state_t state;
  rx_state_t next_state;
  lane_mode_t mode_q;
  lane_mode_t next_mode_q;
  logic [NIB_W-1:0] lo_nib;
  logic [NIB_W-1:0] next_lo_nib;
  logic push_valid;
  logic [FIFO_W-1:0] push_data;
  logic fifo_ready;
  logic next_overflow;
  logic next_active;

  always_comb begin
    next_state = state;
    next_mode_q = mode_q;
    next_lo_nib = lo_nib;
    push_valid = 1'b0;
    push_data = '0;
    unique case (state)
      ST_IDLE: begin
        next_mode_q = mode_select;
        if (port_enable && mode_select == MODE_CELL) begin
          next_state = ST_CELL;
        end else if (port_enable && mode_select == MODE_MII) begin
          next_state = ST_MII_LO;
        end
        // SMII and the reserved code stay idle and read no lane.
      end
      ST_CELL: begin
        if (!port_enable || mode_select != mode_q) begin
          next_state = ST_IDLE;
        end else if (link_rise) begin
          // Lane 4 and lanes 3:0 carry the byte; the upper bits come from
          // lanes outside this stage and read as zero here.
          push_valid = 1'b1;
          push_data = {s_start, 3'h0, s_lanes};
        end
      end
      ST_MII_LO, ST_MII_HI: begin
        if (!port_enable || mode_select != mode_q) begin
          next_state = ST_IDLE;
        end else if (link_rise) begin
          if (!s_lanes[LANE_VALID]) begin
            next_state = ST_MII_LO;
          end else if (state == ST_MII_LO) begin
            next_lo_nib = s_lanes[NIB_W-1:0];
            next_state = ST_MII_HI;
          end else begin
            // Every byte passes unfiltered; filtering happens downstream.
            push_valid = 1'b1;
            push_data = {1'b0, s_lanes[NIB_W-1:0], lo_nib};
            next_state = ST_MII_LO;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_overflow = rx_overflow || (push_valid && !fifo_ready);
    if (state == ST_IDLE) begin
      next_overflow = 1'b0;
    end
    next_active = next_state != ST_IDLE;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      mode_q <= MODE_CELL;
      lo_nib <= NIB_RESET;
      rx_overflow <= 1'b0;
      rx_active <= 1'b0;
    end else begin
      state <= next_state;
      mode_q <= next_mode_q;
      lo_nib <= next_lo_nib;
      rx_overflow <= next_overflow;
      rx_active <= next_active;
    end
  end

  // FIFO, then an output register so every output leaves a flip-flop.
  logic f_valid;
  logic [FIFO_W-1:0] f_data;
  logic f_ready;
  logic next_rx_valid;
  logic [7:0] next_rx_byte;
  logic next_rx_start;

  rx_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) rx_fifo_i (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_valid(push_valid),
    .in_ready(fifo_ready),
    .in_data(push_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  always_comb begin
    f_ready = !rx_valid || rx_ready;
    next_rx_valid = rx_valid;
    next_rx_byte = rx_byte;
    next_rx_start = rx_start;
    if (f_ready) begin
      next_rx_valid = f_valid;
      next_rx_byte = f_data[OUT_BYTE_MSB:OUT_BYTE_LSB];
      next_rx_start = f_data[OUT_START_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_valid <= 1'b0;
      rx_byte <= BYTE_RESET;
      rx_start <= 1'b0;
    end else begin
      rx_valid <= next_rx_valid;
      rx_byte <= next_rx_byte;
      rx_start <= next_rx_start;
    end
  end
endmodule : cell_mii_rx_pin_mux

//--- tb/cell_mii_rx_pin_mux_checker.sv
// Port checks for the shared-lane receive stage.
// Assumes one ref_clk domain with arst_n as its reset.
`timescale 1ns/1ps
module cell_mii_rx_pin_mux_checker
  import rx_lane_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic arst_n,
  // Inputs.
  input wire logic port_enable,
  input wire rx_lane_pkg::lane_mode_t mode_select,
  input wire logic link_rx_clk,
  input wire logic rx_ready,
  // Outputs.
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_start,
  input wire logic rx_overflow,
  input wire logic rx_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_cell_edge;
    $rose(link_rx_clk) && rx_active && mode_select == MODE_CELL;
  endsequence
  sequence s_stalled;
    rx_valid && !rx_ready;
  endsequence
  a_hold_out: assert property (s_stalled |=> rx_valid && $stable({rx_start, rx_byte}))
    else $error("output changed while stalled");
  a_cell_answer: assert property (s_cell_edge |-> ##[1:10] rx_valid)
    else $error("cell edge gave no byte");
  a_off_idle: assert property (!port_enable [*2] |-> !rx_active)
    else $error("disabled port active");
  a_smii_idle: assert property ((mode_select == MODE_SMII) [*2] |-> !rx_active)
    else $error("smii mode active");
  a_start_cell: assert property (rx_valid && rx_start |-> mode_select == MODE_CELL)
    else $error("start flag outside cell mode");
  a_cell_top: assert property (rx_valid && mode_select == MODE_CELL |-> !rx_byte[7:5])
    else $error("cell byte upper bits set");
  a_mii_nostart: assert property (rx_valid && mode_select == MODE_MII |-> !rx_start)
    else $error("start flag in mii mode");
  a_ovf_clear: assert property ($fell(rx_active) |=> !rx_overflow)
    else $error("overflow kept at idle");
endmodule : cell_mii_rx_pin_mux_checker
bind cell_mii_rx_pin_mux cell_mii_rx_pin_mux_checker cell_mii_rx_pin_mux_checker_i (
  .ref_clk, .arst_n, .port_enable, .mode_select, .link_rx_clk, .rx_ready,
  .rx_valid, .rx_byte, .rx_start, .rx_overflow, .rx_active);

//--- tb/phy_rx_model.sv
// Physical-layer device model driving the shared receive pins.
// Assumes the bench calls put on a core clock edge; the clock stops between frames.
`timescale 1ns/1ps
module phy_rx_model (
  // Pins toward the receive stage.
  output logic link_rx_clk,
  output logic cell_start_in,
  output logic [4:0] shared_rx_lanes
);
  initial begin
    link_rx_clk = 1'b0;
    cell_start_in = 1'b0;
    shared_rx_lanes = 5'h1f;
  end
  // Pins change half a link cycle before the rising edge.
  task put(input logic [4:0] lanes, input logic sof);
    shared_rx_lanes <= lanes;
    cell_start_in <= sof;
    #32 link_rx_clk <= 1'b1;
    #32 link_rx_clk <= 1'b0;
  endtask : put
  // Released pins rest at their pull-up level, as on a board.
  task rel;
    shared_rx_lanes <= 5'h1f;
    cell_start_in <= 1'b1;
  endtask : rel
endmodule : phy_rx_model

//--- tb/cell_mii_rx_pin_mux_tb_top.sv
// Self-checking bench for the shared-lane receive stage.
// Assumes the PHY model drives the link pins.
`timescale 1ns/1ps
module cell_mii_rx_pin_mux_tb_top;
  import rx_lane_pkg::*;
  logic ref_clk = 1'b0, arst_n = 1'b0, port_enable = 1'b1, rx_ready = 1'b1;
  lane_mode_t mode_select = MODE_CELL;
  logic link_rx_clk, cell_start_in, rx_valid, rx_start, rx_overflow, rx_active;
  logic [4:0] shared_rx_lanes;
  logic [7:0] rx_byte;
  logic [8:0] got[$];
  int n_mismatch = 0, total_checks = 0;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (rx_valid && rx_ready) got.push_back({rx_start, rx_byte});
  phy_rx_model phy_rx_model_i (.link_rx_clk, .cell_start_in, .shared_rx_lanes);
  cell_mii_rx_pin_mux cell_mii_rx_pin_mux_i (.ref_clk, .arst_n, .port_enable, .mode_select,
    .link_rx_clk, .cell_start_in, .shared_rx_lanes, .rx_valid, .rx_ready, .rx_byte,
    .rx_start, .rx_overflow, .rx_active);
  task check(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task set_cfg(input lane_mode_t m, input logic en);
    @(posedge ref_clk);
    mode_select <= m;
    port_enable <= en;
    repeat (5) @(posedge ref_clk);
    got.delete();
  endtask : set_cfg
  task t_cell;
    set_cfg(MODE_CELL, 1'b1);
    phy_rx_model_i.put(5'h15, 1'b1);
    phy_rx_model_i.put(5'h0a, 1'b0);
    phy_rx_model_i.put(5'h1f, 1'b0);
    phy_rx_model_i.rel();
    repeat (12) @(posedge ref_clk);
    check(got[0], 9'h115);
    check(got[1], 9'h00a);
    check(got[2], 9'h01f);
  endtask : t_cell
  task t_mii;
    set_cfg(MODE_MII, 1'b1);
    phy_rx_model_i.put(5'h13, 1'b0);
    phy_rx_model_i.put(5'h1c, 1'b0);
    phy_rx_model_i.put(5'h05, 1'b0);
    phy_rx_model_i.put(5'h1a, 1'b0);
    phy_rx_model_i.put(5'h16, 1'b0);
    phy_rx_model_i.rel();
    repeat (12) @(posedge ref_clk);
    check(got[0], 9'h0c3);
    check(got[1], 9'h06a);
  endtask : t_mii
  task t_quiet(input lane_mode_t m, input logic en);
    set_cfg(m, en);
    for (int i = 0; i < 4; i++) phy_rx_model_i.put(5'(i + 3), 1'b1);
    phy_rx_model_i.rel();
    repeat (12) @(posedge ref_clk);
    check({8'h00, got.size() == 0}, 9'h001);
  endtask : t_quiet
  task t_fill;
    set_cfg(MODE_CELL, 1'b1);
    rx_ready <= 1'b0;
    for (int i = 0; i < 12; i++) phy_rx_model_i.put(5'(i), i == 0);
    phy_rx_model_i.rel();
    check({8'h00, rx_overflow}, 9'h001);
    @(posedge ref_clk) rx_ready <= 1'b1;
    repeat (20) @(posedge ref_clk);
    check(got[0], 9'h100);
    check({8'h00, got.size() == FIFO_DEPTH + 1}, 9'h001);
    check(got[FIFO_DEPTH], 9'(FIFO_DEPTH));
    set_cfg(MODE_SMII, 1'b1);
    check({8'h00, rx_overflow}, 9'h000);
  endtask : t_fill
  initial begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_cell();
    t_mii();
    t_quiet(MODE_SMII, 1'b1);
    t_quiet(MODE_CELL, 1'b0);
    t_quiet(MODE_RSVD, 1'b1);
    t_fill();
    final_report();
  end
  initial begin
    #40000;
    n_mismatch++;
    final_report();
  end
endmodule : cell_mii_rx_pin_mux_tb_top
